// file: hw/rst_seq_pkg.sv
// Constants, types and register map of the reset and start-up sequencer
package rst_seq_pkg;

	// Clock and derived timing
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned RC_TICK_NS    = 1000;
	localparam int unsigned RC_DIV_CYCLES = RC_TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned RC_DIV_W      = 4;
	localparam int unsigned POWERUP_DELAY_TIMER_MS       = 72;
	localparam int unsigned POWERUP_DELAY_TIMER_TICKS    = POWERUP_DELAY_TIMER_MS * 1000000 / RC_TICK_NS;
	localparam int unsigned POWERUP_DELAY_TIMER_W        = 17;
	localparam int unsigned OST_CYCLES    = 1024;
	localparam int unsigned OST_W         = 11;
	localparam int unsigned FILTER_NS     = 400;
	localparam int unsigned FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned FILTER_W      = 3;

	// Register bus geometry and offsets
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam logic [7:0] OFF_CONFIG     = 8'h00;
	localparam logic [7:0] OFF_STATUS     = 8'h04;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h0C;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] OFF_SCRATCH    = 8'h14;

	// Status register field positions
	localparam int unsigned ST_PD_BIT    = 0;
	localparam int unsigned ST_TO_BIT    = 1;
	localparam int unsigned ST_CAUSE_LSB = 2;
	localparam int unsigned ST_STATE_LSB = 5;

	// Event bits of the interrupt registers
	localparam int unsigned EV_POR       = 0;
	localparam int unsigned EV_EXT_RUN   = 1;
	localparam int unsigned EV_EXT_SLEEP = 2;
	localparam int unsigned EV_WDT       = 3;
	localparam int unsigned EV_BOR       = 4;
	localparam int unsigned EV_WAKE      = 5;
	localparam int unsigned EV_W         = 6;

	typedef enum logic [1:0] {
		LOWPOWER_CRYSTAL_MODE  = 2'h0,
		STD_CRYSTAL_MODE       = 2'h1,
		HIGHSPEED_CRYSTAL_MODE = 2'h2,
		RESISTOR_CAP_MODE      = 2'h3
	} osc_mode_e;

	typedef enum logic [2:0] {
		CAUSE_NONE      = 3'h0,
		CAUSE_POR       = 3'h1,
		CAUSE_EXT_RUN   = 3'h2,
		CAUSE_EXT_SLEEP = 3'h3,
		CAUSE_WDT       = 3'h4,
		CAUSE_BOR       = 3'h5,
		CAUSE_WDT_WAKE  = 3'h6,
		CAUSE_IRQ_WAKE  = 3'h7
	} cause_e;

	// Gray along hold, power-up delay, start-up count, run
	typedef enum logic [1:0] {
		SEQ_HOLD = 2'h0,
		SEQ_POWERUP_DELAY_TIMER = 2'h1,
		SEQ_OST  = 2'h3,
		SEQ_RUN  = 2'h2
	} seq_state_e;

	typedef struct packed {
		logic powerup_delay_enable_n;
		logic osc_select_hi;
		logic osc_select_lo;
	} cfg_s;

	// Unprogrammed configuration reads as ones
	localparam cfg_s CFG_RESET = 3'h7;

endpackage

// file: hw/rst_pin_filter.sv
// Glitch filter for the active-low external reset pin
`timescale 1ns/1ps
`default_nettype none
module rst_pin_filter
	import rst_seq_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_pin_n,
	output logic      o_filt_n
);
	import rst_seq_pkg::*;

	typedef struct packed {
		logic                filt_n;
		logic [FILTER_W-1:0] cnt;
	} filt_state_s;

	filt_state_s r;
	filt_state_s next_r;

	// Output follows the pin only after it differs for the full window
	always_comb begin
		next_r = r;
		if (i_pin_n == r.filt_n) begin
			next_r.cnt = '0;
		end else if (r.cnt == FILTER_W'(FILTER_CYCLES - 1)) begin
			next_r.filt_n = i_pin_n;
			next_r.cnt    = '0;
		end else begin
			next_r.cnt = r.cnt + FILTER_W'(1);
		end
		if (i_sys_rst) begin
			next_r = '{filt_n: 1'b1, cnt: '0};
		end
	end

	always_ff @(posedge i_clk) begin
		r <= next_r;
	end

	assign o_filt_n = r.filt_n;

	// A one-cycle dip never reaches the output
	property p_glitch_rejected;
		@(posedge i_clk) disable iff (i_sys_rst)
		(r.filt_n && !i_pin_n && r.cnt == '0) ##1 i_pin_n |-> o_filt_n [*2];
	endproperty
	a_glitch_rejected: assert property (p_glitch_rejected) // RL7
		else $error("short reset pin pulse passed the filter");

endmodule
`default_nettype wire

// file: hw/rst_seq_core.sv
// Reset source arbitration, status flags and power-up/start-up sequencer
//
// What this block does
// RL1: Tells five reset causes apart
// RL2: Retained registers never initialised by any reset
// RL3: Other registers initialised on every reset cause
// RL4: Watchdog wake-up initialises nothing, resumes execution
// RL5: Timeout and power-down flags record the cause
// RL6: Flag values per cause as encoded
// RL7: Reset pin filtered against short pulses
// RL8: Watchdog reset never drives the pin
// RL9: Power-up delay after power-on, RC-ticked
// RL10: Chip held in reset during power-up delay
// RL11: Configuration bit can drop power-up delay
// RL12: Delay choice by enable bit and cause
// RL13: Start-up count of clock-pin cycles follows
// RL14: Start-up count: crystal modes, power-on/wake only
// RL15: Two-bit oscillator select encodes four modes
// RL16: Crystal modes accept external clock on pin
// RL17: Other party holds pin low to reset
`timescale 1ns/1ps
`default_nettype none
module rst_seq_core
	import rst_seq_pkg::*;
#(
	parameter int unsigned POWERUP_DELAY_TIMER_TICKS_P = POWERUP_DELAY_TIMER_TICKS
) (
	input  wire logic              i_clk,
	input  wire logic              i_sys_rst,
	input  wire logic              i_por_pulse,
	input  wire logic              i_ext_reset_pin_n,
	input  wire logic              i_watchdog_timer,
	input  wire logic              i_brownout_reset,
	input  wire logic              i_sleeping,
	input  wire logic              i_wake_irq,
	input  wire logic              i_clock_in_pin,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [DATA_W-1:0] o_rdata,
	output logic                   o_core_hold,
	output logic                   o_reg_init,
	output logic                   o_wake_resume,
	output logic                   o_timeout_flag_n,
	output logic                   o_powerdown_flag_n,
	output logic      [2:0]        o_reset_cause,
	output logic                   o_irq
);
	import rst_seq_pkg::*;

	typedef struct packed {
		seq_state_e          state;
		cause_e              cause;
		logic                timeout_flag_n;
		logic                powerdown_flag_n;
		logic                need_powerup_delay_timer;
		logic                need_ost;
		logic                wake;
		logic                init_pulse;
		logic                wake_pulse;
		logic [POWERUP_DELAY_TIMER_W-1:0]   powerup_delay_timer_cnt;
		logic [OST_W-1:0]    ost_cnt;
		logic [RC_DIV_W-1:0] rc_div;
		logic                clk_in_prev;
		logic                pin_prev_n;
		logic                bor_prev;
		cfg_s                cfg;
		logic [EV_W-1:0]     irq_status;
		logic [EV_W-1:0]     irq_enable;
		logic [DATA_W-1:0]   scratch;
		logic [DATA_W-1:0]   rdata;
	} seq_regs_s;

	seq_regs_s r;
	seq_regs_s next_r;
	logic      pin_filt_n;
	logic      rc_tick;
	logic      clk_in_rise;
	logic      crystal;
	logic      pin_fall;
	logic      bor_rise;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] clr;

	// RL7: filtered reset pin
	rst_pin_filter u_pin_filter (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_pin_n   (i_ext_reset_pin_n),
		.o_filt_n  (pin_filt_n)
	);

	// Slow tick stands in for the internal RC oscillator
	assign rc_tick     = (r.rc_div == RC_DIV_W'(RC_DIV_CYCLES - 1));
	// RL16: pin edges counted whatever drives them
	assign clk_in_rise = i_clock_in_pin & ~r.clk_in_prev;
	// RL15: every select code except RC is a crystal mode
	assign crystal     = (osc_mode_e'({r.cfg.osc_select_hi, r.cfg.osc_select_lo})
		!= RESISTOR_CAP_MODE);
	assign pin_fall    = r.pin_prev_n & ~pin_filt_n;
	assign bor_rise    = i_brownout_reset & ~r.bor_prev;

	// Next state: sequencer, reset arbitration, register writes
	always_comb begin
		next_r            = r;
		ev                = '0;
		clr               = '0;
		next_r.init_pulse = 1'b0;
		next_r.wake_pulse = 1'b0;
		next_r.rdata      = '0;
		next_r.rc_div     = rc_tick ? '0 : r.rc_div + RC_DIV_W'(1);
		next_r.clk_in_prev = i_clock_in_pin;
		next_r.pin_prev_n  = pin_filt_n;
		next_r.bor_prev    = i_brownout_reset;

		// RL10: counting states keep the core held
		unique case (r.state)
			SEQ_HOLD: begin
				next_r.powerup_delay_timer_cnt = '0;
				next_r.ost_cnt  = '0;
				if (r.need_powerup_delay_timer) begin
					next_r.state = SEQ_POWERUP_DELAY_TIMER;
				end else if (r.need_ost) begin
					next_r.state = SEQ_OST;
				end else begin
					next_r.state = SEQ_RUN;
				end
			end
			SEQ_POWERUP_DELAY_TIMER: begin
				// RL9: counted in RC ticks, not main clock
				if (rc_tick) begin
					if (r.powerup_delay_timer_cnt == POWERUP_DELAY_TIMER_W'(POWERUP_DELAY_TIMER_TICKS_P - 1)) begin
						next_r.state = r.need_ost ? SEQ_OST : SEQ_RUN;
					end else begin
						next_r.powerup_delay_timer_cnt = r.powerup_delay_timer_cnt + POWERUP_DELAY_TIMER_W'(1);
					end
				end
			end
			SEQ_OST: begin
				// RL13: cycles of the clock input pin
				if (clk_in_rise) begin
					if (r.ost_cnt == OST_W'(OST_CYCLES - 1)) begin
						next_r.state = SEQ_RUN;
					end else begin
						next_r.ost_cnt = r.ost_cnt + OST_W'(1);
					end
				end
			end
			SEQ_RUN: begin
				next_r.wake = 1'b0;
			end
		endcase

		// RL1: causes ranked power-on, brown-out, pin, watchdog
		if (i_por_pulse) begin
			// RL6: power-on sets both flags
			next_r.cause            = CAUSE_POR;
			next_r.timeout_flag_n   = 1'b1;
			next_r.powerdown_flag_n = 1'b1;
			next_r.init_pulse       = 1'b1;
			// RL11: enable bit low inserts the delay
			next_r.need_powerup_delay_timer        = ~r.cfg.powerup_delay_enable_n;
			// RL14: start-up count only for crystal
			next_r.need_ost         = crystal;
			next_r.wake             = 1'b0;
			next_r.state            = SEQ_HOLD;
			ev[EV_POR]              = 1'b1;
		end else if (bor_rise) begin
			// RL12: brown-out always takes the power-up delay
			next_r.cause            = CAUSE_BOR;
			next_r.timeout_flag_n   = 1'b1;
			next_r.powerdown_flag_n = 1'b1;
			next_r.init_pulse       = 1'b1;
			next_r.need_powerup_delay_timer        = 1'b1;
			next_r.need_ost         = 1'b0;
			next_r.wake             = 1'b0;
			next_r.state            = SEQ_HOLD;
			ev[EV_BOR]              = 1'b1;
		end else if (i_brownout_reset) begin
			// Supply still low restarts the delay from zero
			next_r.state = SEQ_HOLD;
		end else if (pin_fall) begin
			// RL17: pin low is the other party's request
			next_r.init_pulse = 1'b1;
			next_r.wake       = 1'b0;
			if (i_sleeping) begin
				// RL6: reset in sleep sets timeout, clears power-down
				next_r.cause            = CAUSE_EXT_SLEEP;
				next_r.timeout_flag_n   = 1'b1;
				next_r.powerdown_flag_n = 1'b0;
				ev[EV_EXT_SLEEP]        = 1'b1;
			end else begin
				next_r.cause     = CAUSE_EXT_RUN;
				ev[EV_EXT_RUN]   = 1'b1;
			end
			// Timers already running from power-on keep going
			if (r.state == SEQ_RUN) begin
				next_r.need_powerup_delay_timer = 1'b0;
				// RL14: pin wake from sleep is a wake-up
				next_r.need_ost  = i_sleeping & crystal;
				next_r.state     = SEQ_HOLD;
			end
		end else if (i_watchdog_timer && r.state == SEQ_RUN && pin_filt_n) begin
			if (i_sleeping) begin
				// RL4: wake-up resumes, no register loaded
				// RL6: watchdog wake clears both flags
				next_r.cause            = CAUSE_WDT_WAKE;
				next_r.timeout_flag_n   = 1'b0;
				next_r.powerdown_flag_n = 1'b0;
				next_r.need_powerup_delay_timer        = 1'b0;
				next_r.need_ost         = crystal;
				next_r.wake             = 1'b1;
				ev[EV_WAKE]             = 1'b1;
			end else begin
				// RL8: internal only, the pin stays an input
				// RL6: watchdog reset clears timeout, sets power-down
				next_r.cause            = CAUSE_WDT;
				next_r.timeout_flag_n   = 1'b0;
				next_r.powerdown_flag_n = 1'b1;
				next_r.init_pulse       = 1'b1;
				next_r.need_powerup_delay_timer        = 1'b0;
				next_r.need_ost         = 1'b0;
				next_r.wake             = 1'b0;
				ev[EV_WDT]              = 1'b1;
			end
			next_r.state = SEQ_HOLD;
		end else if (i_wake_irq && i_sleeping && r.state == SEQ_RUN && pin_filt_n) begin
			// Interrupt wake: start-up count, no initialisation
			next_r.cause            = CAUSE_IRQ_WAKE;
			next_r.timeout_flag_n   = 1'b1;
			next_r.powerdown_flag_n = 1'b0;
			next_r.need_powerup_delay_timer        = 1'b0;
			next_r.need_ost         = crystal;
			next_r.wake             = 1'b1;
			next_r.state            = SEQ_HOLD;
			ev[EV_WAKE]             = 1'b1;
		end

		// Resume pulse only if no new event cancelled the wake-up
		if (next_r.wake && r.state != SEQ_RUN && next_r.state == SEQ_RUN) begin
			next_r.wake_pulse = 1'b1;
		end

		// Register writes and read capture
		if (i_wr) begin
			unique case (i_addr)
				OFF_CONFIG:     next_r.cfg        = cfg_s'(i_wdata[2:0]);
				OFF_IRQ_CLEAR:  clr               = i_wdata[EV_W-1:0];
				OFF_IRQ_ENABLE: next_r.irq_enable = i_wdata[EV_W-1:0];
				OFF_SCRATCH:    next_r.scratch    = i_wdata;
				default:        next_r.scratch    = r.scratch;
			endcase
		end
		if (i_rd) begin
			unique case (i_addr)
				OFF_CONFIG:     next_r.rdata = {5'h00, r.cfg};
				OFF_STATUS: begin
					next_r.rdata[ST_PD_BIT]                  = r.powerdown_flag_n;
					next_r.rdata[ST_TO_BIT]                  = r.timeout_flag_n;
					next_r.rdata[ST_CAUSE_LSB +: 3]          = r.cause;
					next_r.rdata[ST_STATE_LSB +: 2]          = r.state;
				end
				OFF_IRQ_STATUS: next_r.rdata = {2'h0, r.irq_status};
				OFF_IRQ_ENABLE: next_r.rdata = {2'h0, r.irq_enable};
				OFF_SCRATCH:    next_r.rdata = r.scratch;
				default:        next_r.rdata = '0;
			endcase
		end

		// Sticky events; a new event beats a clear in the same cycle
		next_r.irq_status = (r.irq_status & ~clr) | ev;

		// RL3: block reset; RL2: scratch keeps its content
		if (i_sys_rst) begin
			next_r                  = '0;
			next_r.state            = SEQ_HOLD;
			next_r.cause            = CAUSE_NONE;
			next_r.timeout_flag_n   = 1'b1;
			next_r.powerdown_flag_n = 1'b1;
			next_r.pin_prev_n       = 1'b1;
			next_r.cfg              = CFG_RESET;
			next_r.scratch          = r.scratch;
		end
	end

	always_ff @(posedge i_clk) begin
		r <= next_r;
	end

	// Outputs: data from flops, hold also follows live sources
	assign o_rdata            = r.rdata;
	assign o_core_hold        = (r.state != SEQ_RUN) | ~pin_filt_n | i_brownout_reset;
	assign o_reg_init         = r.init_pulse;
	assign o_wake_resume      = r.wake_pulse;
	assign o_timeout_flag_n   = r.timeout_flag_n;
	assign o_powerdown_flag_n = r.powerdown_flag_n;
	assign o_reset_cause      = r.cause;
	assign o_irq              = |(r.irq_status & r.irq_enable);

	// Power-on always loads reset values and sets both flags
	sequence s_por_seen;
		i_por_pulse && !i_sys_rst;
	endsequence
	property p_por_init;
		@(posedge i_clk) disable iff (i_sys_rst)
		s_por_seen |=> o_reg_init && o_timeout_flag_n && o_powerdown_flag_n;
	endproperty
	a_por_init: assert property (p_por_init) // RL3
		else $error("power-on did not initialise and set flags");

	property p_wake_no_init;
		@(posedge i_clk) disable iff (i_sys_rst)
		$rose(r.wake) |-> !o_reg_init && r.cause inside {CAUSE_WDT_WAKE, CAUSE_IRQ_WAKE};
	endproperty
	a_wake_no_init: assert property (p_wake_no_init) // RL4
		else $error("wake-up loaded reset values");

	property p_wdt_flags;
		@(posedge i_clk) disable iff (i_sys_rst)
		(o_reg_init && r.cause == CAUSE_WDT) |-> !o_timeout_flag_n && o_powerdown_flag_n;
	endproperty
	a_wdt_flags: assert property (p_wdt_flags) // RL6
		else $error("watchdog reset flags wrong");

	property p_wake_flags;
		@(posedge i_clk) disable iff (i_sys_rst)
		(r.wake && r.cause == CAUSE_WDT_WAKE) |-> !o_timeout_flag_n && !o_powerdown_flag_n;
	endproperty
	a_wake_flags: assert property (p_wake_flags) // RL5
		else $error("watchdog wake flags wrong");

	property p_powerup_delay_timer_holds;
		@(posedge i_clk) disable iff (i_sys_rst)
		r.state == SEQ_POWERUP_DELAY_TIMER |-> o_core_hold;
	endproperty
	a_powerup_delay_timer_holds: assert property (p_powerup_delay_timer_holds) // RL10
		else $error("core released during power-up delay");

	property p_powerup_delay_timer_skipped;
		@(posedge i_clk) disable iff (i_sys_rst)
		(r.state == SEQ_HOLD && !r.need_powerup_delay_timer && !i_brownout_reset && !i_por_pulse)
		|=> r.state != SEQ_POWERUP_DELAY_TIMER;
	endproperty
	a_powerup_delay_timer_skipped: assert property (p_powerup_delay_timer_skipped) // RL11
		else $error("power-up delay ran while disabled");

	property p_powerup_delay_timer_ends;
		@(posedge i_clk) disable iff (i_sys_rst)
		(r.state == SEQ_POWERUP_DELAY_TIMER && rc_tick && r.powerup_delay_timer_cnt == POWERUP_DELAY_TIMER_W'(POWERUP_DELAY_TIMER_TICKS_P - 1)
			&& !i_por_pulse && !i_brownout_reset)
		|=> r.state == (r.need_ost ? SEQ_OST : SEQ_RUN);
	endproperty
	a_powerup_delay_timer_ends: assert property (p_powerup_delay_timer_ends) // RL9
		else $error("power-up delay end wrong");

	sequence s_ost_last;
		r.state == SEQ_OST && clk_in_rise && r.ost_cnt == OST_W'(OST_CYCLES - 1)
			&& !i_por_pulse && !i_brownout_reset && !pin_fall;
	endsequence
	property p_ost_ends;
		@(posedge i_clk) disable iff (i_sys_rst)
		s_ost_last |=> r.state == SEQ_RUN;
	endproperty
	a_ost_ends: assert property (p_ost_ends) // RL13
		else $error("start-up count end wrong");

	property p_ost_causes;
		@(posedge i_clk) disable iff (i_sys_rst)
		$rose(r.state == SEQ_OST) |-> r.need_ost && r.cause inside
			{CAUSE_POR, CAUSE_EXT_SLEEP, CAUSE_WDT_WAKE, CAUSE_IRQ_WAKE};
	endproperty
	a_ost_causes: assert property (p_ost_causes) // RL14
		else $error("start-up count after wrong cause");

endmodule
`default_nettype wire

// file: bench/osc_pin_partner.sv
// Far-side model: reset pin driver and external clock source
`timescale 1ns/1ps
`default_nettype none
module osc_pin_partner (
	input  wire logic i_clk,
	output logic      o_pin_n,
	output logic      o_clk_pin
);
	logic [1:0] div;

	// Pin idles released, oscillator starts low
	initial begin
		o_pin_n = 1'b1;
		o_clk_pin = 1'b0;
		div = 2'h0;
	end

	// external clock drive
	// Free-running source, four system cycles per period, so
	// every rising edge is wide enough to be sampled
	always @(posedge i_clk) begin
		div <= div + 2'h1;
		o_clk_pin <= div[1];
	end

	// pin held low
	// Holds the pin low for n cycles, then lets it go high
	task automatic press(input int n);
		@(posedge i_clk);
		o_pin_n <= 1'b0;
		repeat (n) @(posedge i_clk);
		o_pin_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench of the reset and start-up sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("wrong value at %0t: got %0h want %0h", $time, a, e); end end
module tb_top;
	import rst_seq_pkg::*;
	localparam int unsigned PW = 6;
	logic              i_clk;
	logic              i_sys_rst;
	logic              i_por_pulse;
	logic              i_watchdog_timer;
	logic              i_brownout_reset;
	logic              i_sleeping;
	logic              i_wake_irq;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata;
	logic              i_wr;
	logic              i_rd;
	logic [DATA_W-1:0] o_rdata;
	logic              o_core_hold;
	logic              o_reg_init;
	logic              o_wake_resume;
	logic              o_timeout_flag_n;
	logic              o_powerdown_flag_n;
	logic [2:0]        o_reset_cause;
	logic              o_irq;
	logic              pin_n;
	logic              clk_pin;
	int                n_errors;
	int                total_checks;
	int                exp_n;
	logic [31:0]       lfsr_q;
	logic [2:0]        m_cause;
	logic              m_to;
	logic              m_pd;
	logic              m_init;
	logic              m_res;
	logic              m_xtal;
	logic              m_dly;
	logic              m_sleep;
	logic [7:0]        m_irq;
	logic [7:0]        m_en;
	logic [7:0]        m_scr;
	logic [7:0]        d;

	rst_seq_core #(.POWERUP_DELAY_TIMER_TICKS_P(PW)) u_rst_seq_core (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_por_pulse(i_por_pulse),
		.i_ext_reset_pin_n(pin_n), .i_watchdog_timer(i_watchdog_timer),
		.i_brownout_reset(i_brownout_reset), .i_sleeping(i_sleeping),
		.i_wake_irq(i_wake_irq), .i_clock_in_pin(clk_pin), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_core_hold(o_core_hold), .o_reg_init(o_reg_init),
		.o_wake_resume(o_wake_resume), .o_timeout_flag_n(o_timeout_flag_n),
		.o_powerdown_flag_n(o_powerdown_flag_n), .o_reset_cause(o_reset_cause),
		.o_irq(o_irq));
	osc_pin_partner u_osc_pin_partner (.i_clk(i_clk), .o_pin_n(pin_n), .o_clk_pin(clk_pin));

	// 10 MHz system clock
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	// Pseudo-random source for data and glitch widths
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// One bus cycle; read data lands in d
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(posedge i_clk);
		i_wr <= w;
		i_rd <= !w;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		`CHK(d, e)
	endtask

	// Status in RUN and sticky event bits against the model
	task automatic regs_chk();
		rd_chk(OFF_STATUS, {1'b0, 2'b10, m_cause, m_to, m_pd});
		rd_chk(OFF_IRQ_STATUS, m_irq);
	endtask

	// Expected outcome of event k: 0 por, 1 wdt, 2 wake, 3 bor, 4 pin, 5 glitch
	task automatic model(input int k);
		m_init = (k == 0 || k == 3 || k == 4 || (k == 1 && !m_sleep));
		exp_n = ((k == 0 && m_dly) || k == 3) ? PW * 10 : 0;
		if (m_xtal && (k == 0 || (k != 3 && k != 5 && m_sleep)))
			exp_n += 4 * OST_CYCLES;
		m_res = (k == 1 || k == 2) && m_sleep;
		case (k)
			0: begin
				{m_cause, m_to, m_pd} = {CAUSE_POR, 2'b11};
				m_irq[EV_POR] = 1'b1;
			end
			1: begin
				{m_cause, m_to, m_pd} = m_sleep ? {CAUSE_WDT_WAKE, 2'b00} : {CAUSE_WDT, 2'b01};
				m_irq[m_sleep ? EV_WAKE : EV_WDT] = 1'b1;
			end
			2: begin
				{m_cause, m_to, m_pd} = {CAUSE_IRQ_WAKE, 2'b10};
				m_irq[EV_WAKE] = 1'b1;
			end
			3: begin
				{m_cause, m_to, m_pd} = {CAUSE_BOR, 2'b11};
				m_irq[EV_BOR] = 1'b1;
			end
			4: begin
				if (m_sleep)
					{m_cause, m_to, m_pd} = {CAUSE_EXT_SLEEP, 2'b10};
				else
					m_cause = CAUSE_EXT_RUN;
				m_irq[m_sleep ? EV_EXT_SLEEP : EV_EXT_RUN] = 1'b1;
			end
			default: m_init = 1'b0;
		endcase
	endtask

	// Fire one event, compare the answer, then time the hold
	task automatic apply(input int k, input int lo, input logic s);
		int n;
		logic rs;
		if (s) begin
			@(posedge i_clk);
			i_sleeping <= 1'b1;
			m_sleep = 1'b1;
		end
		model(k);
		n = 0;
		if (k >= 4) begin
			fork
				u_osc_pin_partner.press(lo);
			join_none
			do begin
				@(posedge i_clk);
				#1 n++;
			end while (o_reg_init !== 1'b1 && n < 14);
		end else begin
			@(posedge i_clk);
			i_por_pulse <= (k == 0);
			i_watchdog_timer <= (k == 1);
			i_wake_irq <= (k == 2);
			i_brownout_reset <= (k == 3);
			@(posedge i_clk);
			{i_por_pulse, i_watchdog_timer, i_wake_irq, i_brownout_reset} <= 4'h0;
			#1;
		end
		`CHK(o_reg_init, m_init)
		`CHK(o_reset_cause, m_cause)
		`CHK({o_timeout_flag_n, o_powerdown_flag_n}, {m_to, m_pd})
		`CHK(o_irq, |(m_irq & m_en))
		rs = 1'b0;
		n = 0;
		while (o_core_hold !== 1'b0 && n < 6000) begin
			@(posedge i_clk);
			#1 n++;
			rs |= (o_wake_resume === 1'b1);
		end
		@(posedge i_clk);
		#1 rs |= (o_wake_resume === 1'b1);
		`CHK(rs, m_res)
		`CHK(n >= exp_n * 3 / 4 && n <= exp_n + 40, 1'b1)
		if (m_sleep) begin
			@(posedge i_clk);
			i_sleeping <= 1'b0;
			m_sleep = 1'b0;
		end
		regs_chk();
	endtask

	task automatic results();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Cuts a hang short well past the longest expected run
	initial begin
		#(60000 * 100);
		n_errors++;
		results();
	end

	// Main sequence
	initial begin
		{i_sys_rst, i_por_pulse, i_watchdog_timer, i_brownout_reset} = 4'h8;
		{i_sleeping, i_wake_irq, i_wr, i_rd} = 4'h0;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		{n_errors, total_checks, exp_n} = '0;
		lfsr_q = 32'h7f23;
		{m_cause, m_to, m_pd, m_xtal, m_dly, m_sleep} = {CAUSE_NONE, 5'b11000};
		{m_irq, m_en} = 16'h0000;
		repeat (6) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		rd_chk(OFF_CONFIG, 8'h07);
		regs_chk();
		rd_chk(8'h20, 8'h00);
		lfsr_q = lfsr(lfsr_q);
		m_scr = lfsr_q[7:0];
		bus(1'b1, OFF_SCRATCH, m_scr);
		bus(1'b1, OFF_STATUS, 8'hFF);
		// RC mode without delay: no time-out except the power-up delay after brown-out
		apply(0, 0, 1'b0);
		apply(2, 0, 1'b1);
		lfsr_q = lfsr(lfsr_q);
		apply(5, 1 + lfsr_q % 3, 1'b0);
		apply(5, 1, 1'b0);
		apply(4, 6, 1'b0);
		apply(3, 0, 1'b0);
		m_en = 8'h3F;
		bus(1'b1, OFF_IRQ_ENABLE, m_en);
		apply(1, 0, 1'b0);
		bus(1'b1, OFF_IRQ_CLEAR, 8'h09);
		m_irq &= ~8'h09;
		regs_chk();
		`CHK(o_irq, |(m_irq & m_en))
		bus(1'b1, OFF_IRQ_CLEAR, 8'hFF);
		m_irq = 8'h00;
		rd_chk(OFF_IRQ_ENABLE, m_en);
		`CHK(o_irq, 1'b0)
		// Low-power crystal with delay on: both timers run on power-on, only the start-up count on the wake-ups
		bus(1'b1, OFF_CONFIG, 8'h00);
		{m_xtal, m_dly} = 2'b11;
		rd_chk(OFF_CONFIG, 8'h00);
		apply(0, 0, 1'b0);
		apply(1, 0, 1'b1);
		apply(4, 6, 1'b1);
		// Every oscillator mode with the delay off
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, OFF_CONFIG, 8'h04 | m[7:0]);
			{m_xtal, m_dly} = {m != 3, 1'b0};
			apply(0, 0, 1'b0);
		end
		rd_chk(OFF_SCRATCH, m_scr);
		results();
	end
endmodule
`default_nettype wire
